// ---- core/cer_pkg.sv ----
// Package for the channel estimation responder: types, encodings, constants
package cer_pkg;

   // ***************************************************************
   // Request flag encodings
   // ***************************************************************
   localparam logic [1:0] CER_FLAG_NONE = 2'h0;
   localparam logic [1:0] CER_FLAG_REPORT = 2'h1;
   localparam logic [1:0] CER_FLAG_EXT_ACK = 2'h2;
   localparam logic [1:0] CER_FLAG_PART_ACK = 2'h3;

   // ***************************************************************
   // Report transmission settings
   // ***************************************************************
   localparam logic [3:0] CER_RPT_MIN_REPEAT = 4'h4;
   localparam logic [1:0] CER_RATE_HALF = 2'h0;
   localparam logic [1:0] CER_RATE_TWO_THIRDS = 2'h1;

   // ***************************************************************
   // Field widths and reset values
   // ***************************************************************
   localparam int CER_TONE_W = 8;
   localparam logic [CER_TONE_W-1:0] CER_TONE_RST = 8'hff;
   localparam logic [2:0] CER_MOD_RST = 3'h0;
   localparam logic [3:0] CER_REP_RST = 4'h4;
   localparam logic CER_ILV_RST = 1'b0;
   localparam logic [1:0] CER_RATE_RST = CER_RATE_HALF;
   localparam logic [7:0] CER_RS_RST = 8'hff;

   // ***************************************************************
   // Response kinds
   // ***************************************************************
   typedef enum logic [1:0] {
      CER_RSP_REPORT = 2'b00,
      CER_RSP_EXT_ACK = 2'b01,
      CER_RSP_PART_ACK = 2'b10
   } cer_rsp_kind_t;

   // Full recommendation
   typedef struct packed {
      logic [CER_TONE_W-1:0] tone_mask;
      logic [2:0] modulation;
      logic [3:0] repetition;
      logic interleaver_mode;
      logic [1:0] code_rate;
      logic [7:0] max_rs_size;
   } cer_reco_t;

   // Transmission settings for an outgoing frame
   typedef struct packed {
      logic robust_comm_mode;
      logic [1:0] code_rate;
      logic [3:0] repetition;
   } cer_txset_t;

   // Received request event
   typedef struct packed {
      logic is_request_message;
      logic header_ok;
      logic [1:0] parameter_request_flag;
      logic [15:0] source_addr;
   } cer_rx_t;

   // Outgoing response descriptor
   typedef struct packed {
      cer_rsp_kind_t kind;
      logic unable_to_comply;
      logic partial;
      logic [15:0] dest_addr;
      cer_reco_t reco;
      cer_txset_t txset;
   } cer_rsp_t;

endpackage

// ---- core/cer_txset.sv ----
// Transmission settings selector for responses
`timescale 1ns/1ps
`default_nettype none
module cer_txset
   import cer_pkg::*;
(
   input wire logic is_report,
   input wire logic [3:0] link_repetition,
   input wire logic [1:0] link_code_rate,
   output var cer_txset_t txset
);

   logic [3:0] rep_floor;

   assign rep_floor = (link_repetition < CER_RPT_MIN_REPEAT) ? CER_RPT_MIN_REPEAT
                      : link_repetition;

   always_comb
   begin
      if (is_report)
      begin
         txset.robust_comm_mode = 1'b1;
         txset.code_rate = CER_RATE_HALF;
         txset.repetition = rep_floor;
      end
      else
      begin
         txset.robust_comm_mode = 1'b0;
         txset.code_rate = link_code_rate;
         txset.repetition = link_repetition;
      end
   end

endmodule
`default_nettype wire

// ---- core/cer_responder.sv ----
// Channel estimation responder: decodes requests and issues recommendations
//
// Contract
// - A recommendation carries tone mask, modulation, repetition, interleaver, code rate and max RS size.
// - A dedicated request message is answered by a report message with the full recommendation.
// - A clean header with request flag 01 is answered by a report message.
// - A clean header with request flag 10 is answered by an extended acknowledgement with the full recommendation.
// - A clean header with request flag 11 is answered by a normal acknowledgement with a partial set.
// - If the extended acknowledgement cannot carry the report, one is still sent marked unable to comply.
// - Report messages go in robust mode at code rate 1/2 with at least 4 repetitions.
`timescale 1ns/1ps
`default_nettype none
module cer_responder
   import cer_pkg::*;
#(
   parameter bit EXT_ACK_CAPABLE = 1'b1
)
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic rx_valid,
   input wire cer_rx_t rx,
   output logic rx_ready,
   input wire cer_reco_t reco_in,
   input wire logic [3:0] link_repetition,
   input wire logic [1:0] link_code_rate,
   output logic rsp_valid,
   input wire logic rsp_ready,
   output var cer_rsp_t rsp
);

   // ***************************************************************
   // Request decode
   // ***************************************************************
   logic want_rsp;
   cer_rsp_kind_t kind_d;
   logic unable_d;
   logic partial_d;
   cer_txset_t txset_w;
   cer_reco_t reco_d;
   logic is_report_w;

   always_comb
   begin
      want_rsp = 1'b0;
      kind_d = CER_RSP_REPORT;
      unable_d = 1'b0;
      partial_d = 1'b0;
      if (rx.is_request_message)
      begin
         want_rsp = 1'b1;
         kind_d = CER_RSP_REPORT;
      end
      else if (rx.header_ok)
      begin
         unique case (rx.parameter_request_flag)
            CER_FLAG_NONE:
            begin
               want_rsp = 1'b0;
            end
            CER_FLAG_REPORT:
            begin
               want_rsp = 1'b1;
               kind_d = CER_RSP_REPORT;
            end
            CER_FLAG_EXT_ACK:
            begin
               want_rsp = 1'b1;
               kind_d = CER_RSP_EXT_ACK;
               unable_d = !EXT_ACK_CAPABLE;
            end
            CER_FLAG_PART_ACK:
            begin
               want_rsp = 1'b1;
               kind_d = CER_RSP_PART_ACK;
               partial_d = 1'b1;
            end
         endcase
      end
      // Bad header: no response
   end

   // Partial set keeps modulation, repetition and code rate only
   always_comb
   begin
      reco_d = reco_in;
      if (partial_d)
      begin
         reco_d.tone_mask = '0;
         reco_d.interleaver_mode = 1'b0;
         reco_d.max_rs_size = '0;
      end
      else if (unable_d)
      begin
         reco_d = '0;
      end
   end

   assign is_report_w = (kind_d == CER_RSP_REPORT);

   cer_txset u_txset
   (
      .is_report(is_report_w),
      .link_repetition(link_repetition),
      .link_code_rate(link_code_rate),
      .txset(txset_w)
   );

   // ***************************************************************
   // Response holding stage
   // ***************************************************************
   typedef enum logic {
      CER_ST_IDLE = 1'b0,
      CER_ST_HOLD = 1'b1
   } cer_hold_st_t;

   cer_hold_st_t state_q;
   cer_hold_st_t state_d;
   logic take_w;
   cer_rsp_kind_t kind_q;
   logic unable_q;
   logic partial_q;
   logic [15:0] dest_q;
   cer_reco_t reco_q;
   cer_txset_t txset_q;

   // Stage frees in the cycle its response is consumed
   assign rx_ready = (state_q == CER_ST_IDLE) || rsp_ready;
   assign take_w = rx_ready && rx_valid && want_rsp;
   assign rsp_valid = (state_q == CER_ST_HOLD);
   assign rsp = {kind_q, unable_q, partial_q, dest_q, reco_q, txset_q};

   always_comb
   begin
      state_d = state_q;
      unique case (state_q)
         CER_ST_IDLE:
         begin
            if (take_w)
            begin
               state_d = CER_ST_HOLD;
            end
         end
         CER_ST_HOLD:
         begin
            if (rsp_ready && !take_w)
            begin
               state_d = CER_ST_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_q <= CER_ST_IDLE;
      end
      else
      begin
         state_q <= state_d;
      end
   end

   // ***************************************************************
   // Response fields, loaded on each accepted request that wants a response
   // ***************************************************************
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         kind_q <= CER_RSP_REPORT;
         unable_q <= 1'b0;
         partial_q <= 1'b0;
      end
      else if (take_w)
      begin
         kind_q <= kind_d;
         unable_q <= unable_d;
         partial_q <= partial_d;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         dest_q <= '0;
      end
      else if (take_w)
      begin
         dest_q <= rx.source_addr;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         reco_q <= '0;
      end
      else if (take_w)
      begin
         reco_q <= reco_d;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         txset_q <= '0;
      end
      else if (take_w)
      begin
         txset_q <= txset_w;
      end
   end

endmodule
`default_nettype wire

// ---- verif/cer_sink.sv ----
// Response consumer model of the peer
`timescale 1ns/1ps
`default_nettype none
module cer_sink
(
   input wire logic ref_clk,
   input wire logic rst_n,
   output logic rsp_ready
);
   // Random stalls on the response path
   always_ff @(posedge ref_clk or negedge rst_n)
      if (!rst_n)
         rsp_ready <= 1'b0;
      else
         rsp_ready <= ($urandom % 3) != 0;
endmodule
`default_nettype wire

// ---- verif/cer_sva.sv ----
// Assertions for the responder ports
`timescale 1ns/1ps
`default_nettype none
module cer_sva
   import cer_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic rx_valid,
   input wire cer_rx_t rx,
   input wire logic rx_ready,
   input wire cer_reco_t reco_in,
   input wire logic [3:0] link_repetition,
   input wire logic [1:0] link_code_rate,
   input wire logic rsp_valid,
   input wire logic rsp_ready,
   input wire cer_rsp_t rsp
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   wire logic tk = rx_valid && rx_ready;
   wire logic hk = tk && !rx.is_request_message && rx.header_ok;
   wire logic [1:0] fl = rx.parameter_request_flag;
   a_msg_report: assert property (tk && rx.is_request_message
      |=> rsp_valid && rsp.kind == CER_RSP_REPORT) else $error("no report");
   a_flag_report: assert property (hk && fl == CER_FLAG_REPORT
      |=> rsp_valid && rsp.kind == CER_RSP_REPORT) else $error("no report");
   a_ext_ack: assert property (hk && fl == CER_FLAG_EXT_ACK
      |=> rsp_valid && rsp.kind == CER_RSP_EXT_ACK) else $error("no ext ack");
   a_part_ack: assert property (hk && fl == CER_FLAG_PART_ACK |=> rsp_valid
      && rsp.partial && rsp.reco.tone_mask == '0) else $error("bad part ack");
   a_no_reply: assert property (tk && !rx.is_request_message
      && (!rx.header_ok || fl == CER_FLAG_NONE) |=> !rsp_valid) else $error("reply");
   a_report_mode: assert property (rsp_valid && rsp.kind == CER_RSP_REPORT
      |-> rsp.txset.robust_comm_mode && rsp.txset.code_rate == CER_RATE_HALF
      && rsp.txset.repetition >= CER_RPT_MIN_REPEAT) else $error("report mode");
   a_full_reco: assert property (tk && rx.is_request_message
      |=> rsp.reco == $past(reco_in)) else $error("reco lost");
   a_unable_mark: assert property (rsp_valid && rsp.unable_to_comply
      |-> rsp.kind == CER_RSP_EXT_ACK && rsp.reco == '0) else $error("bad unable mark");
   a_rsp_hold: assert property (rsp_valid && !rsp_ready
      |=> rsp_valid && $stable(rsp)) else $error("rsp dropped");
   cover property (hk && fl == CER_FLAG_EXT_ACK);
   cover property (hk && fl == CER_FLAG_PART_ACK);
   cover property (rsp_valid && !rsp_ready);
   cover property (rsp_valid && rsp.unable_to_comply);
endmodule
bind cer_responder cer_sva cer_sva_i
(
   .ref_clk(ref_clk),
   .rst_n(rst_n),
   .rx_valid(rx_valid),
   .rx(rx),
   .rx_ready(rx_ready),
   .reco_in(reco_in),
   .link_repetition(link_repetition),
   .link_code_rate(link_code_rate),
   .rsp_valid(rsp_valid),
   .rsp_ready(rsp_ready),
   .rsp(rsp)
);
`default_nettype wire

// ---- verif/tb_channel_estimation_responder.sv ----
// Testbench for the channel estimation responder
`timescale 1ns/1ps
`default_nettype none
module tb_channel_estimation_responder;
   import cer_pkg::*;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic rx_valid = 1'b0;
   cer_rx_t rx = '0;
   cer_reco_t reco_in = '0;
   logic [3:0] link_repetition = '0;
   logic [1:0] link_code_rate = '0;
   logic rx_ready, rsp_valid, rsp_ready;
   logic nc_rx_ready, nc_rsp_valid;
   cer_rsp_t rsp;
   cer_rsp_t nc_rsp;
   int n_fail = 0;
   int n_compared = 0;
   always #12.5 ref_clk = ~ref_clk;
   cer_responder cer_responder_i
   (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .rx_valid(rx_valid),
      .rx(rx),
      .rx_ready(rx_ready),
      .reco_in(reco_in),
      .link_repetition(link_repetition),
      .link_code_rate(link_code_rate),
      .rsp_valid(rsp_valid),
      .rsp_ready(rsp_ready),
      .rsp(rsp)
   );
   // Second copy without extended acknowledgement support
   if (1)
   begin : g_nc
      cer_responder #(.EXT_ACK_CAPABLE(1'b0)) cer_responder_i
      (
         .ref_clk(ref_clk),
         .rst_n(rst_n),
         .rx_valid(rx_valid),
         .rx(rx),
         .rx_ready(nc_rx_ready),
         .reco_in(reco_in),
         .link_repetition(link_repetition),
         .link_code_rate(link_code_rate),
         .rsp_valid(nc_rsp_valid),
         .rsp_ready(rsp_ready),
         .rsp(nc_rsp)
      );
   end
   cer_sink cer_sink_i
   (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .rsp_ready(rsp_ready)
   );
   task conclude;
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   function cer_rsp_t ex(input cer_rx_t r, input bit cap);
      cer_rsp_t e;
      e = '0;
      e.dest_addr = r.source_addr;
      e.reco = reco_in;
      e.txset = {1'b0, link_code_rate, link_repetition};
      if (r.is_request_message || r.parameter_request_flag == CER_FLAG_REPORT)
      begin
         e.kind = CER_RSP_REPORT;
         e.txset.robust_comm_mode = 1'b1;
         e.txset.code_rate = CER_RATE_HALF;
         e.txset.repetition = link_repetition;
         if (link_repetition < CER_RPT_MIN_REPEAT)
            e.txset.repetition = CER_RPT_MIN_REPEAT;
      end
      else if (r.parameter_request_flag == CER_FLAG_EXT_ACK)
      begin
         e.kind = CER_RSP_EXT_ACK;
         e.unable_to_comply = !cap;
         if (!cap)
            e.reco = '0;
      end
      else
      begin
         e.kind = CER_RSP_PART_ACK;
         e.partial = 1'b1;
         e.reco.tone_mask = '0;
         e.reco.interleaver_mode = 1'b0;
         e.reco.max_rs_size = '0;
      end
      return e;
   endfunction
   task send(input cer_rx_t r);
      int n;
      n = 0;
      rx = r;
      rx_valid = 1'b1;
      while (rx_ready !== 1'b1)
      begin
         @(posedge ref_clk);
         #2;
         n++;
         if (n > 20)
         begin
            $display("[ERR] rx_ready exp 1 got %b", rx_ready);
            n_fail++;
            conclude;
         end
      end
      @(posedge ref_clk);
      #2;
      rx_valid = 1'b0;
      n_compared++;
      if (!(r.is_request_message || (r.header_ok && r.parameter_request_flag != CER_FLAG_NONE)))
      begin
         if ({rsp_valid, nc_rsp_valid} !== 2'b00)
         begin
            $display("[ERR] rsp_valid exp 00 got %b%b", rsp_valid, nc_rsp_valid);
            n_fail++;
         end
      end
      else
      begin
         while (!(rsp_valid === 1'b1 && rsp_ready === 1'b1) && n < 40)
         begin
            @(posedge ref_clk);
            #2;
            n++;
         end
         if (!(rsp_valid === 1'b1 && rsp_ready === 1'b1))
         begin
            $display("[ERR] rsp handshake exp 1 got %b", rsp_valid && rsp_ready);
            n_fail++;
            conclude;
         end
         if (rsp !== ex(r, 1'b1))
         begin
            $display("[ERR] rsp exp %h got %h", ex(r, 1'b1), rsp);
            n_fail++;
         end
         if ({nc_rsp_valid, nc_rsp} !== {1'b1, ex(r, 1'b0)})
         begin
            $display("[ERR] nc_rsp exp %h got %h", {1'b1, ex(r, 1'b0)}, {nc_rsp_valid, nc_rsp});
            n_fail++;
         end
      end
      @(posedge ref_clk);
      #2;
   endtask
   initial
   begin
      cer_rx_t r;
      void'($urandom(32'hece1));
      repeat (10) @(posedge ref_clk);
      #2;
      rst_n = 1'b1;
      for (int i = 0; i < 48; i++)
      begin
         r = cer_rx_t'($urandom);
         if (i < 16)
            {r.is_request_message, r.header_ok, r.parameter_request_flag} = i[3:0];
         reco_in = cer_reco_t'($urandom);
         link_repetition = 4'($urandom);
         link_code_rate = 2'($urandom);
         send(r);
         if (i == 15 || i == 47)
            $display("test %0d done", i);
      end
      conclude;
   end
endmodule
`default_nettype wire
